/* src/dcs_consts.vh */
// constants for the disk controller status and address word block
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH

// port selection codes
`define DCS_SEL_CTRL 4'h0
`define DCS_SEL_CART_ADDR 4'h1
`define DCS_SEL_FIX_ADDR 4'h2
`define DCS_SEL_HEAD_CMD 4'h3
`define DCS_SEL_RECAL_CMD 4'h4
`define DCS_SEL_STATUS 4'h8
`define DCS_SEL_CUR_ADDR 4'h9
`define DCS_SEL_RD_CART 4'ha
`define DCS_SEL_RD_FIX 4'hb
`define DCS_SEL_UNIT_STAT 4'hc
`define DCS_SEL_ERR_POS 4'hd
`define DCS_SEL_ERR_PAT 4'he

// control and status word fields
`define DCS_B_READY 0
`define DCS_F_FUNC_LO 1
`define DCS_F_FUNC_HI 3
`define DCS_B_IE 6
`define DCS_B_IDLE 7
`define DCS_F_UNIT_LO 8
`define DCS_F_UNIT_HI 9
`define DCS_B_OPI 10
`define DCS_B_DCK 11
`define DCS_B_DTL 12
`define DCS_B_DE 14
`define DCS_B_ERR 15
`define DCS_F_ATTN_LO 16
`define DCS_F_ATTN_HI 19
`define DCS_F_ECC_LO 20
`define DCS_F_ECC_HI 21
`define DCS_B_BAD_SECTOR_ERROR_INHIBIT 22
`define DCS_B_SSE 23
`define DCS_B_IR 24
`define DCS_B_MTN 25
`define DCS_B_LARGE 26
`define DCS_B_AUTO_BAD_SECTOR_INHIBIT 27
`define DCS_B_WINH 28
`define DCS_B_FMT 29

// drive command word flags
`define DCS_B_RTZ 6
`define DCS_B_CYL_FLAG 13
`define DCS_B_HEAD_FLAG 14
`define DCS_B_CTRL_FLAG 15

// address and error word widths
`define DCS_CART_ADDR_W 16
`define DCS_FIX_ADDR_W 19
`define DCS_ERR_POS_W 13
`define DCS_ERR_PAT_W 11

// function timeout: 150 ms of 4 ns cycles, sized to the timer width
`define DCS_TIMEOUT_CYC 26'h23c3460

`define DCS_RST_WORD 32'h0000_0000

`endif

/* src/dcs_func_timer.v */
// function timeout counter
`timescale 1ns/1ps
`default_nettype none

module dcs_func_timer #(
    parameter CNT_W = 26,
    parameter [CNT_W-1:0] LIMIT = 26'h23c3460
) (
    input wire sys_clk,
    input wire rst_n,
    input wire start,
    input wire stop,
    input wire disable_to,
    output reg expire_ff
);

    reg [CNT_W-1:0] cnt_ff;
    reg run_ff;

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= {CNT_W{1'b0}};
            run_ff <= 1'b0;
            expire_ff <= 1'b0;
        end
        else
        begin
            expire_ff <= 1'b0;
            if (start)
            begin
                cnt_ff <= {CNT_W{1'b0}};
                run_ff <= 1'b1;
            end
            else if (stop)
                run_ff <= 1'b0;
            else if (run_ff && !disable_to)
            begin
                // expiry fires once at the limit, then the timer stops
                if (cnt_ff == LIMIT - 1'b1)
                begin
                    expire_ff <= 1'b1;
                    run_ff <= 1'b0;
                end
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* src/dcs_byte_pick.v */
// byte-at-a-time reader for a two-byte drive status
`timescale 1ns/1ps
`default_nettype none

module dcs_byte_pick (
    input wire sys_clk,
    input wire rst_n,
    input wire load,
    input wire [15:0] status_in,
    input wire take,
    output wire [7:0] byte_out
);

    reg [15:0] hold_ff;
    reg idx_ff;

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_ff <= 16'h0000;
            idx_ff <= 1'b0;
        end
        else if (load)
        begin
            hold_ff <= status_in;
            idx_ff <= 1'b0;
        end
        else if (take)
            idx_ff <= ~idx_ff;
    end

    // low byte first, then high byte, then wraps
    assign byte_out = idx_ff ? hold_ff[15:8] : hold_ff[7:0];

endmodule

`default_nettype wire

/* src/dcs_status_regs.v */
// disk controller status, address and error word bank
//
// Behaviour
// RULE1: current address reads back in read/write address layout, last sector handled.
// RULE2: operation incomplete flags a function not done within about 150 ms.
// RULE3: drive status goes to host one byte per read.
// RULE4: error position returned on bits 12 to 0 after read error.
// RULE5: error correction pattern for 11-bit burst on bits 10 to 0.
// RULE6: bits 12 and 11 driven low with the correction pattern.
// RULE7: host head select: head in 3..0, bit 14 set, 13 and 15 clear.
// RULE8: host recalibrate: bit 6 and 15 set, bits 13 and 14 clear.
// RULE9: cartridge address: sector 5..0, head bit 6, cylinder 15..7.
// RULE10: large-drive address: sector 4..0, head 8..5, cylinder 18..9.
// RULE11: status bit 0 set while selected drive is ready.
// RULE12: status echoes function code, interrupt enable and unit number.
// RULE13: status bit 7 set while controller ready for a function.
// RULE14: status carries incomplete, check, late, drive and composite error flags.
// RULE15: per-drive attention flags in bits 16 to 19.
// RULE16: ecc comparison outcome in status bits 20 and 21.
// RULE17: status bit 23 set when skip-sector marker seen.
// RULE18: status bit 24 set when interrupt request raised.
// RULE19: status bit 26 set when large drive selected.
// RULE20: echo diagnostic bit 25, skip error inhibit 22, auto skip inhibit 27.
// RULE21: status bit 28 echoes timeout disable and write block.
// RULE22: status bit 29 echoes large-drive format request.
// RULE23: error cause encoded in four flags with composite set.
// RULE24: control word bits 16 to 19 clear matching attention flags.
// RULE25: unused status bits 4, 5, 13, 30, 31 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_consts.vh"

module dcs_status_regs #(
    parameter TO_W = 26,
    parameter [TO_W-1:0] TIMEOUT_CYC = `DCS_TIMEOUT_CYC
) (
    input wire sys_clk,
    input wire rst_n,
    input wire port_strobe,
    input wire port_write,
    input wire [3:0] port_sel,
    input wire [31:0] bus_y_in,
    output reg [31:0] bus_y_out_ff,
    output reg bus_y_valid_ff,
    output reg slow_interrupt_request_ff,
    input wire [1:0] large_unit_number,
    input wire large_unit_present,
    input wire [3:0] selected_unit_ready,
    input wire func_done,
    input wire err_evt,
    input wire [3:0] err_cause,
    input wire [3:0] unit_attention_evt,
    input wire ecc_valid,
    input wire [1:0] ecc_outcome,
    input wire [`DCS_ERR_POS_W-1:0] err_position,
    input wire [`DCS_ERR_PAT_W-1:0] err_pattern,
    input wire err_info_valid,
    input wire bad_sector_marker_evt,
    input wire cur_addr_upd,
    input wire [`DCS_FIX_ADDR_W-1:0] cur_addr_in,
    input wire unit_stat_load,
    input wire [15:0] unit_stat_in,
    output reg func_start_ff,
    output reg [31:0] ctrl_word_ff,
    output reg [`DCS_CART_ADDR_W-1:0] cartridge_drive_data_address_ff,
    output reg [`DCS_FIX_ADDR_W-1:0] fixed_drive_data_address_ff,
    output reg head_cmd_ff,
    output reg [3:0] head_number_ff,
    output reg return_to_track_zero_ff
);

    reg rst_meta_ff;
    reg rst_sync_ff;
    reg busy_ff;
    reg [3:0] err_ff;
    reg [3:0] unit_attention_ff;
    reg [1:0] ecc_ff;
    reg bad_sector_marker_seen_ff;
    reg irq_raised_ff;
    reg [`DCS_FIX_ADDR_W-1:0] cur_addr_ff;
    reg [`DCS_ERR_POS_W-1:0] err_pos_ff;
    reg [`DCS_ERR_PAT_W-1:0] err_pat_ff;
    reg [31:0] nxt_rd_word;
    reg [31:0] status_word;
    wire sys_rst_n;
    wire ctrl_wr;
    wire start_req;
    wire timeout_pulse;
    wire finish;
    wire [7:0] unit_byte;
    wire [1:0] unit_number;
    wire write_block;

    // reset release through two stages
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign sys_rst_n = rst_sync_ff;

    assign ctrl_wr = port_strobe && port_write && (port_sel == `DCS_SEL_CTRL);
    // a control word with the idle bit cleared starts the function
    assign start_req = ctrl_wr && !bus_y_in[`DCS_B_IDLE];
    assign unit_number = ctrl_word_ff[`DCS_F_UNIT_HI:`DCS_F_UNIT_LO];
    assign write_block = ctrl_word_ff[`DCS_B_WINH];
    assign finish = busy_ff && (func_done || timeout_pulse);

    dcs_func_timer #(
        .CNT_W(TO_W),
        .LIMIT(TIMEOUT_CYC)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst_n(sys_rst_n),
        .start(start_req),
        .stop(func_done),
        .disable_to(write_block),
        .expire_ff(timeout_pulse)
    ); // RULE2

    dcs_byte_pick u_unit_bytes (
        .sys_clk(sys_clk),
        .rst_n(sys_rst_n),
        .load(unit_stat_load),
        .status_in(unit_stat_in),
        .take(port_strobe && !port_write && (port_sel == `DCS_SEL_UNIT_STAT)),
        .byte_out(unit_byte)
    ); // RULE3

    // control word, drive commands and address words
    always @(posedge sys_clk or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            ctrl_word_ff <= `DCS_RST_WORD;
            func_start_ff <= 1'b0;
            cartridge_drive_data_address_ff <= {`DCS_CART_ADDR_W{1'b0}};
            fixed_drive_data_address_ff <= {`DCS_FIX_ADDR_W{1'b0}};
            head_cmd_ff <= 1'b0;
            head_number_ff <= 4'h0;
            return_to_track_zero_ff <= 1'b0;
        end
        else
        begin
            func_start_ff <= start_req;
            head_cmd_ff <= 1'b0;
            return_to_track_zero_ff <= 1'b0;
            if (ctrl_wr)
                ctrl_word_ff <= bus_y_in; // RULE12 RULE20 RULE21 RULE22
            if (port_strobe && port_write)
            begin
                case (port_sel)
                    `DCS_SEL_CART_ADDR:
                        cartridge_drive_data_address_ff <= bus_y_in[`DCS_CART_ADDR_W-1:0]; // RULE9
                    `DCS_SEL_FIX_ADDR:
                        fixed_drive_data_address_ff <= bus_y_in[`DCS_FIX_ADDR_W-1:0]; // RULE10
                    `DCS_SEL_HEAD_CMD:
                    begin
                        // words with the wrong flag pattern are ignored
                        if (bus_y_in[`DCS_B_HEAD_FLAG] && !bus_y_in[`DCS_B_CYL_FLAG] &&
                            !bus_y_in[`DCS_B_CTRL_FLAG])
                        begin
                            head_cmd_ff <= 1'b1; // RULE7
                            head_number_ff <= bus_y_in[3:0];
                        end
                    end
                    `DCS_SEL_RECAL_CMD:
                    begin
                        if (bus_y_in[`DCS_B_RTZ] && bus_y_in[`DCS_B_CTRL_FLAG] &&
                            !bus_y_in[`DCS_B_CYL_FLAG] && !bus_y_in[`DCS_B_HEAD_FLAG])
                            return_to_track_zero_ff <= 1'b1; // RULE8
                    end
                    default:
                    begin
                        head_cmd_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // function progress, error and event flags
    always @(posedge sys_clk or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            busy_ff <= 1'b0;
            err_ff <= 4'h0;
            unit_attention_ff <= 4'h0;
            ecc_ff <= 2'b00;
            bad_sector_marker_seen_ff <= 1'b0;
            irq_raised_ff <= 1'b0;
            slow_interrupt_request_ff <= 1'b0;
        end
        else
        begin
            // a new function clears the previous outcome
            if (start_req)
            begin
                busy_ff <= 1'b1;
                err_ff <= 4'h0;
                ecc_ff <= 2'b00;
            end
            else if (finish)
                busy_ff <= 1'b0; // RULE13
            if (busy_ff && timeout_pulse && !func_done)
                err_ff <= err_ff | 4'b0001; // RULE2 RULE23
            // an error event in the starting cycle still lands
            else if (err_evt)
                err_ff <= (start_req ? 4'h0 : err_ff) | err_cause; // RULE23
            // set wins over the clear from the host
            unit_attention_ff <= (unit_attention_ff &
                ~(ctrl_wr ? bus_y_in[`DCS_F_ATTN_HI:`DCS_F_ATTN_LO] : 4'h0)) | unit_attention_evt; // RULE15 RULE24
            if (ecc_valid)
                ecc_ff <= ecc_outcome; // RULE16
            if (bad_sector_marker_evt)
                bad_sector_marker_seen_ff <= 1'b1; // RULE17
            else if (ctrl_wr && bus_y_in[`DCS_B_SSE])
                bad_sector_marker_seen_ff <= 1'b0;
            if (finish && ctrl_word_ff[`DCS_B_IE])
            begin
                irq_raised_ff <= 1'b1; // RULE18
                slow_interrupt_request_ff <= 1'b1;
            end
            else if (ctrl_wr)
            begin
                irq_raised_ff <= 1'b0;
                slow_interrupt_request_ff <= 1'b0;
            end
        end
    end

    // drive-side reports held for readback
    always @(posedge sys_clk or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            cur_addr_ff <= {`DCS_FIX_ADDR_W{1'b0}};
            err_pos_ff <= {`DCS_ERR_POS_W{1'b0}};
            err_pat_ff <= {`DCS_ERR_PAT_W{1'b0}};
        end
        else
        begin
            if (cur_addr_upd)
                cur_addr_ff <= cur_addr_in; // RULE1
            if (err_info_valid)
            begin
                err_pos_ff <= err_position; // RULE4
                err_pat_ff <= err_pattern; // RULE5
            end
        end
    end

    always @*
    begin
        status_word = 32'h0000_0000; // RULE25
        status_word[`DCS_B_READY] = selected_unit_ready[unit_number]; // RULE11
        status_word[`DCS_F_FUNC_HI:`DCS_F_FUNC_LO] = ctrl_word_ff[`DCS_F_FUNC_HI:`DCS_F_FUNC_LO]; // RULE12
        status_word[`DCS_B_IE] = ctrl_word_ff[`DCS_B_IE];
        status_word[`DCS_F_UNIT_HI:`DCS_F_UNIT_LO] = unit_number;
        status_word[`DCS_B_IDLE] = !busy_ff; // RULE13
        status_word[`DCS_B_OPI] = err_ff[0]; // RULE14
        status_word[`DCS_B_DCK] = err_ff[1];
        status_word[`DCS_B_DTL] = err_ff[2];
        status_word[`DCS_B_DE] = err_ff[3];
        status_word[`DCS_B_ERR] = |err_ff; // RULE23
        status_word[`DCS_F_ATTN_HI:`DCS_F_ATTN_LO] = unit_attention_ff; // RULE15
        status_word[`DCS_F_ECC_HI:`DCS_F_ECC_LO] = ecc_ff; // RULE16
        status_word[`DCS_B_BAD_SECTOR_ERROR_INHIBIT] = ctrl_word_ff[`DCS_B_BAD_SECTOR_ERROR_INHIBIT]; // RULE20
        status_word[`DCS_B_SSE] = bad_sector_marker_seen_ff; // RULE17
        status_word[`DCS_B_IR] = irq_raised_ff; // RULE18
        status_word[`DCS_B_MTN] = ctrl_word_ff[`DCS_B_MTN]; // RULE20
        status_word[`DCS_B_LARGE] = large_unit_present && (unit_number == large_unit_number); // RULE19
        status_word[`DCS_B_AUTO_BAD_SECTOR_INHIBIT] = ctrl_word_ff[`DCS_B_AUTO_BAD_SECTOR_INHIBIT]; // RULE20
        status_word[`DCS_B_WINH] = write_block; // RULE21
        status_word[`DCS_B_FMT] = ctrl_word_ff[`DCS_B_FMT]; // RULE22
    end

    always @*
    begin
        nxt_rd_word = 32'h0000_0000;
        case (port_sel)
            `DCS_SEL_STATUS:
                nxt_rd_word = status_word;
            `DCS_SEL_CUR_ADDR:
                nxt_rd_word[`DCS_FIX_ADDR_W-1:0] = cur_addr_ff; // RULE1
            `DCS_SEL_RD_CART:
                nxt_rd_word[`DCS_CART_ADDR_W-1:0] = cartridge_drive_data_address_ff;
            `DCS_SEL_RD_FIX:
                nxt_rd_word[`DCS_FIX_ADDR_W-1:0] = fixed_drive_data_address_ff;
            `DCS_SEL_UNIT_STAT:
                nxt_rd_word[7:0] = unit_byte; // RULE3
            `DCS_SEL_ERR_POS:
                nxt_rd_word[`DCS_ERR_POS_W-1:0] = err_pos_ff; // RULE4
            `DCS_SEL_ERR_PAT:
                nxt_rd_word[`DCS_ERR_PAT_W-1:0] = err_pat_ff; // RULE5 RULE6
            default:
                nxt_rd_word = 32'h0000_0000;
        endcase
    end

    // read data registered, answered one cycle after the strobe
    always @(posedge sys_clk or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            bus_y_out_ff <= 32'h0000_0000;
            bus_y_valid_ff <= 1'b0;
        end
        else
        begin
            bus_y_valid_ff <= port_strobe && !port_write;
            if (port_strobe && !port_write)
                bus_y_out_ff <= nxt_rd_word;
        end
    end

endmodule

`default_nettype wire

/* tb/dcs_status_checker.sv */
// port checker for the status and address word bank
`timescale 1ns/1ps
`default_nettype none
module dcs_status_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic port_strobe,
    input wire logic port_write,
    input wire logic [3:0] port_sel,
    input wire logic [31:0] bus_y_in,
    input wire logic [31:0] bus_y_out_ff,
    input wire logic bus_y_valid_ff,
    input wire logic slow_interrupt_request_ff,
    input wire logic func_done,
    input wire logic func_start_ff,
    input wire logic [31:0] ctrl_word_ff,
    input wire logic [15:0] cartridge_drive_data_address_ff,
    input wire logic [18:0] fixed_drive_data_address_ff,
    input wire logic head_cmd_ff,
    input wire logic [3:0] head_number_ff,
    input wire logic return_to_track_zero_ff
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    wire wr = port_strobe && port_write;
    wire rd = port_strobe && !port_write;
    wire ctl = wr && port_sel == 4'h0;
    a_read_valid: assert property (rd |=> bus_y_valid_ff)
        else $error("read without data valid");
    a_ctrl_echo: assert property (ctl |=> ctrl_word_ff == $past(bus_y_in))
        else $error("control word not kept");
    a_start_pulse: assert property (func_start_ff == $past(ctl && !bus_y_in[7]))
        else $error("start pulse wrong");
    a_head_take: assert property (wr && port_sel == 4'h3 && bus_y_in[15:13] == 3'b010
        |=> head_cmd_ff && head_number_ff == $past(bus_y_in[3:0]))
        else $error("head select lost");
    a_head_refuse: assert property (wr && port_sel == 4'h3 && bus_y_in[15:13] != 3'b010 |=> !head_cmd_ff)
        else $error("bad head select taken");
    a_recal_take: assert property (wr && port_sel == 4'h4 && bus_y_in[6] && bus_y_in[15:13] == 3'b100
        |=> return_to_track_zero_ff)
        else $error("recalibrate lost");
    a_pattern_high: assert property (rd && port_sel == 4'he |=> bus_y_out_ff[31:11] == 21'h0)
        else $error("pattern upper bits set");
    a_cart_addr: assert property (wr && port_sel == 4'h1
        |=> cartridge_drive_data_address_ff == $past(bus_y_in[15:0]))
        else $error("cartridge address not kept");
    a_fix_addr: assert property (wr && port_sel == 4'h2
        |=> fixed_drive_data_address_ff == $past(bus_y_in[18:0]))
        else $error("large address not kept");
    a_irq_set: assert property (func_done && ctrl_word_ff[6] && !ctrl_word_ff[7] && !ctl
        |=> slow_interrupt_request_ff)
        else $error("no interrupt on completion");
    a_irq_clear: assert property (ctl && !func_done |=> !slow_interrupt_request_ff)
        else $error("interrupt not cleared");
    cover property (head_cmd_ff);
    cover property (slow_interrupt_request_ff);
    cover property (rd && port_sel == 4'hd);
endmodule
bind dcs_status_regs dcs_status_checker i_chk (.sys_clk, .rst_n, .port_strobe, .port_write, .port_sel,
    .bus_y_in, .bus_y_out_ff, .bus_y_valid_ff, .slow_interrupt_request_ff, .func_done, .func_start_ff,
    .ctrl_word_ff, .cartridge_drive_data_address_ff, .fixed_drive_data_address_ff, .head_cmd_ff,
    .head_number_ff, .return_to_track_zero_ff);
`default_nettype wire

/* tb/dcs_host_model.sv */
// host port model making one port access per call
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model (
    input wire logic sys_clk,
    input wire logic [31:0] bus_y_out_ff,
    input wire logic bus_y_valid_ff,
    output logic port_strobe,
    output logic port_write,
    output logic [3:0] port_sel,
    output logic [31:0] bus_y_in
);
    initial
    begin
        port_strobe = 1'b0;
        port_write = 1'b0;
        port_sel = 4'h0;
        bus_y_in = 32'h0;
    end
    task acc(input logic w, input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
        @(negedge sys_clk);
        port_strobe = 1'b1;
        port_write = w;
        port_sel = s;
        bus_y_in = d;
        @(negedge sys_clk);
        port_strobe = 1'b0;
        // inverse after release, so stale data never matches
        bus_y_in = ~d;
        q = (!w && bus_y_valid_ff === 1'b1) ? bus_y_out_ff : 32'hx;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// testbench for the status and address word bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic port_strobe, port_write, func_done, err_evt, ecc_valid, err_info_valid;
    logic bad_sector_marker_evt, cur_addr_upd, unit_stat_load, large_unit_present;
    logic bus_y_valid_ff, slow_interrupt_request_ff, func_start_ff, head_cmd_ff, return_to_track_zero_ff;
    logic [3:0] port_sel, selected_unit_ready, err_cause, unit_attention_evt, head_number_ff;
    logic [1:0] large_unit_number, ecc_outcome;
    logic [31:0] bus_y_in, bus_y_out_ff, ctrl_word_ff, q;
    logic [12:0] err_position;
    logic [10:0] err_pattern;
    logic [18:0] cur_addr_in, fixed_drive_data_address_ff;
    logic [15:0] unit_stat_in, cartridge_drive_data_address_ff;
    logic [31:0] cmd [4] = '{32'h4009, 32'h600b, 32'h8040, 32'hc040};
    logic [1:0] pul [4] = '{2'b01, 2'b00, 2'b10, 2'b00};
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    always #2 sys_clk = ~sys_clk;
    dcs_host_model i_host (.sys_clk, .bus_y_out_ff, .bus_y_valid_ff, .port_strobe, .port_write, .port_sel,
        .bus_y_in);
    // short timeout so the expiry path runs in a few cycles
    dcs_status_regs #(.TIMEOUT_CYC(26'd20)) i_dut (.sys_clk, .rst_n, .port_strobe, .port_write, .port_sel,
        .bus_y_in, .bus_y_out_ff, .bus_y_valid_ff, .slow_interrupt_request_ff, .large_unit_number,
        .large_unit_present, .selected_unit_ready, .func_done, .err_evt, .err_cause, .unit_attention_evt,
        .ecc_valid, .ecc_outcome, .err_position, .err_pattern, .err_info_valid, .bad_sector_marker_evt,
        .cur_addr_upd, .cur_addr_in, .unit_stat_load, .unit_stat_in, .func_start_ff, .ctrl_word_ff,
        .cartridge_drive_data_address_ff, .fixed_drive_data_address_ff, .head_cmd_ff, .head_number_ff,
        .return_to_track_zero_ff);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] s, input logic [31:0] d);
        i_host.acc(1'b1, s, d, q);
    endtask
    task rd(input logic [3:0] s, input logic [31:0] exp);
        i_host.acc(1'b0, s, 32'h5a5a_5a5a, q);
        chk(q, exp);
    endtask
    task done_pulse;
        @(negedge sys_clk);
        func_done = 1'b1;
        @(negedge sys_clk);
        func_done = 1'b0;
    endtask
    task summarize;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            error_cnt++;
            summarize;
        end
    end
    initial
    begin
        {func_done, err_evt, ecc_valid, err_info_valid, bad_sector_marker_evt} = 5'h0;
        {cur_addr_upd, unit_stat_load, err_cause, unit_attention_evt, ecc_outcome} = 12'h0;
        {err_position, err_pattern, cur_addr_in, unit_stat_in} = 59'h0;
        selected_unit_ready = 4'b0101;
        large_unit_number = 2'd2;
        large_unit_present = 1'b1;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd(4'h8, 32'h0000_0081);
        rd(4'hf, 32'h0);
        wr(4'h1, {16'h0, 9'd511, 1'b1, 6'd39});
        rd(4'ha, {16'h0, 9'd511, 1'b1, 6'd39});
        wr(4'h2, {13'h0, 10'd560, 4'd13, 5'd31});
        rd(4'hb, {13'h0, 10'd560, 4'd13, 5'd31});
        @(negedge sys_clk);
        {cur_addr_upd, cur_addr_in, unit_attention_evt, bad_sector_marker_evt} = {1'b1, 19'h4b2c7, 4'ha, 1'b1};
        {unit_stat_load, unit_stat_in, err_info_valid, err_position, err_pattern} = {17'h1c3a5, 1'b1, 13'h1abc, 11'h5a5};
        @(negedge sys_clk);
        {cur_addr_upd, unit_attention_evt, bad_sector_marker_evt, unit_stat_load, err_info_valid} = 8'h0;
        rd(4'h9, {13'h0, 19'h4b2c7});
        rd(4'h8, 32'h008a_0081);
        wr(4'h0, 32'h0082_0080);
        rd(4'h8, 32'h0008_0081);
        for (int i = 0; i < 2; i++)
        begin
            i_host.acc(1'b0, 4'hc, 32'h0, q);
            chk({24'h0, q[7:0]}, i ? 32'hc3 : 32'ha5);
        end
        rd(4'hd, 32'h1abc);
        rd(4'he, 32'h5a5);
        for (int i = 0; i < 4; i++)
        begin
            wr(i < 2 ? 4'h3 : 4'h4, cmd[i]);
            chk({30'h0, return_to_track_zero_ff, head_cmd_ff}, {30'h0, pul[i]});
        end
        chk({28'h0, head_number_ff}, 32'h9);
        wr(4'h0, 32'h3a48_024a);
        chk({31'h0, func_start_ff}, 32'h1);
        rd(4'h8, 32'h3e40_024b);
        repeat (30) @(negedge sys_clk);
        rd(4'h8, 32'h3e40_024b);
        done_pulse;
        rd(4'h8, 32'h3f40_02cb);
        chk({31'h0, slow_interrupt_request_ff}, 32'h1);
        wr(4'h0, 32'h0);
        repeat (30) @(negedge sys_clk);
        rd(4'h8, 32'h0000_8481);
        chk({31'h0, slow_interrupt_request_ff}, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h0, 32'h0);
            @(negedge sys_clk);
            {err_evt, err_cause, ecc_valid, ecc_outcome} = {1'b1, 4'h1 << i, 1'b1, i[1:0]};
            @(negedge sys_clk);
            {err_evt, ecc_valid} = 2'b00;
            done_pulse;
            rd(4'h8, 32'h8081 | (32'h400 << (i == 3 ? 4 : i)) | (i << 20));
        end
        summarize;
    end
endmodule
`default_nettype wire
